// ### include/crc_compute_unit_params.svh
// Offsets, field positions, reset values and byte counts of the checksum unit
// Included by the checksum unit design file; definitions only
`ifndef CRC_COMPUTE_UNIT_PARAMS_SVH
`define CRC_COMPUTE_UNIT_PARAMS_SVH

// ============================================================
// Register offsets
`define CRC_OFS_DATA 8'h00
`define CRC_OFS_SCRATCH 8'h04
`define CRC_OFS_CTRL 8'h08
`define CRC_OFS_INIT 8'h10
`define CRC_OFS_POLY 8'h14

// ============================================================
// Control register fields
`define CRC_CTRL_SOFT_RST 0
`define CRC_CTRL_WSEL_LSB 3
`define CRC_CTRL_WSEL_MSB 4
`define CRC_CTRL_IREV_LSB 5
`define CRC_CTRL_IREV_MSB 6
`define CRC_CTRL_OREV 7

// ============================================================
// Reset values
`define CRC_DATA_RESET 32'hFFFFFFFF
`define CRC_INIT_RESET 32'hFFFFFFFF
`define CRC_POLY_RESET 32'h04C11DB7
`define CRC_SCRATCH_RESET 8'h00

// ============================================================
// Fold cycles per access, one byte per clock
`define CRC_BYTES_BYTE 3'h1
`define CRC_BYTES_HALF 3'h2
`define CRC_BYTES_WORD 3'h4

`endif

// ### include/crc_pkg.sv
// Types shared by the checksum unit and its byte folding stage
// Assumes nothing beyond a SystemVerilog compiler
package crc_pkg;

    // ============================================================
    // Field encodings
    typedef enum logic [1:0] {
        WIDTH_32 = 2'b00,
        WIDTH_16 = 2'b01,
        WIDTH_8 = 2'b10,
        WIDTH_7 = 2'b11
    } poly_width_e;

    typedef enum logic [1:0] {
        REV_NONE = 2'b00,
        REV_BYTE = 2'b01,
        REV_HALF = 2'b10,
        REV_WORD = 2'b11
    } in_rev_e;

    typedef enum logic [1:0] {
        ACC_BYTE = 2'b00,
        ACC_HALF = 2'b01,
        ACC_WORD = 2'b10,
        ACC_BAD = 2'b11
    } access_size_e;

    typedef enum logic {
        ENG_IDLE = 1'b0,
        ENG_FOLD = 1'b1
    } engine_e;

    // ============================================================
    // Whole state of the unit
    typedef struct packed {
        logic [31:0] remainder;
        logic [7:0] scratch_value;
        logic soft_reset;
        poly_width_e poly_width_sel;
        in_rev_e input_bit_reverse;
        logic output_bit_reverse;
        logic [31:0] initial_value;
        logic [31:0] poly_coefficients;
        logic [31:0] rdata;
        engine_e engine;
        logic [31:0] shift_data;
        logic [2:0] bytes_left;
        logic pend_valid;
        logic [31:0] pend_data;
        logic [2:0] pend_bytes;
    } crc_state_s;

endpackage

// ### rtl/crc_byte_fold.sv
// Combinational fold of one byte into the running remainder
// Assumes the remainder sits in the low bits for widths below 32
`timescale 1ns/1ps
module crc_byte_fold
    import crc_pkg::*;
(
    input wire logic [31:0] remainder_i,
    input wire logic [7:0] byte_i,
    input wire logic [31:0] poly_i,
    input wire poly_width_e width_i,
    output logic [31:0] remainder_o
);

    logic [31:0] mask;
    logic [4:0] top;
    logic [31:0] r;
    logic fb;

    // ============================================================
    // Width select
    // width decode
    always_comb
    begin
        unique case (width_i)
            WIDTH_32:
            begin
                mask = 32'hFFFFFFFF;
                top = 5'h1F;
            end
            WIDTH_16:
            begin
                mask = 32'h0000FFFF;
                top = 5'h0F;
            end
            WIDTH_8:
            begin
                mask = 32'h000000FF;
                top = 5'h07;
            end
            WIDTH_7:
            begin
                mask = 32'h0000007F;
                top = 5'h06;
            end
        endcase
    end

    // ============================================================
    // Bit serial division, eight steps
    always_comb
    begin
        r = remainder_i & mask;
        fb = 1'b0;
        for (int b = 7; b >= 0; b--)
        begin
            fb = r[top] ^ byte_i[b];
            r = (r << 1) & mask;
            if (fb)
            begin
                r = r ^ (poly_i & mask);
            end
        end
        remainder_o = r;
    end

endmodule

// ### rtl/crc_compute_unit.sv
// Memory mapped checksum unit with one-entry input buffer
// Assumes a plain register port: strobes one cycle, read data next cycle
// Function
// - Polynomial register defaults to the 32-bit Ethernet polynomial 0x4C11DB7.
// - Word write folds in four cycles, half-word two, byte one.
// - Each data write folds into the existing remainder, not a new one.
// - Data register takes word, half and byte writes; others words only.
// - Data register reads return the remainder after output reversal.
// - Data register holds all ones after system reset.
// - Control bit 0 reloads the remainder and clears itself.
// - Scratch byte holds any value, untouched by soft reset.
// - Control bits 4:3 pick width 32, 16, 8 or 7.
// - Control bits 6:5 reverse input per byte, half-word or word.
// - Initial value register holds the start value, resets all ones.
// - Polynomial resets to 0x04C11DB7; narrow ones use low bits.
// - A write arriving during folding is buffered if the buffer is empty, else dropped; master never waits.
`timescale 1ns/1ps
`include "crc_compute_unit_params.svh"
module crc_compute_unit
    import crc_pkg::*;
#(
    parameter int ADDR_W = 8
)
(
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic [ADDR_W-1:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic [1:0] size_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [31:0] rdata_o,
    output logic busy_o
);

    // ============================================================
    // Reset state
    // data all ones
    localparam crc_state_s RESET_STATE = '{
        remainder: `CRC_DATA_RESET,
        scratch_value: `CRC_SCRATCH_RESET,
        soft_reset: 1'b0,
        poly_width_sel: WIDTH_32,
        input_bit_reverse: REV_NONE,
        output_bit_reverse: 1'b0,
        initial_value: `CRC_INIT_RESET,
        poly_coefficients: `CRC_POLY_RESET,
        rdata: 32'h00000000,
        engine: ENG_IDLE,
        shift_data: 32'h00000000,
        bytes_left: 3'h0,
        pend_valid: 1'b0,
        pend_data: 32'h00000000,
        pend_bytes: 3'h0
    };

    crc_state_s st;
    crc_state_s next_st;

    logic [31:0] folded;
    logic [7:0] addr_lo;
    logic is_word;
    logic size_ok;
    logic data_wr;
    logic [31:0] packed_in;
    logic [31:0] rev_in;
    logic [2:0] in_bytes;
    logic [31:0] read_value;

    // ============================================================
    // Helpers

    // Reverse bits inside each unit of the chosen size
    function automatic logic [31:0] rev_units(
        input logic [31:0] d,
        input in_rev_e unit
    );
        logic [31:0] o;
        o = d;
        for (int i = 0; i < 32; i++)
        begin
            unique case (unit)
                REV_NONE: o[i] = d[i];
                REV_BYTE: o[i] = d[(i & ~7) | (7 - (i & 7))];
                REV_HALF: o[i] = d[(i & ~15) | (15 - (i & 15))];
                REV_WORD: o[i] = d[31 - i];
            endcase
        end
        return o;
    endfunction

    // Reverse the low bits that hold the remainder
    function automatic logic [31:0] rev_low(
        input logic [31:0] d,
        input poly_width_e w
    );
        logic [31:0] o;
        int n;
        o = d;
        unique case (w)
            WIDTH_32: n = 32;
            WIDTH_16: n = 16;
            WIDTH_8: n = 8;
            WIDTH_7: n = 7;
        endcase
        for (int i = 0; i < 32; i++)
        begin
            if (i < n)
            begin
                o[i] = d[n - 1 - i];
            end
        end
        return o;
    endfunction

    // ============================================================
    // Byte folding stage
    // fold into remainder
    crc_byte_fold u_crc_byte_fold (
        .remainder_i(st.remainder),
        .byte_i(st.shift_data[31:24]),
        .poly_i(st.poly_coefficients),
        .width_i(st.poly_width_sel),
        .remainder_o(folded)
    );

    // ============================================================
    // Access decode
    assign addr_lo = addr_i[7:0];
    assign is_word = (access_size_e'(size_i) == ACC_WORD);
    assign size_ok = (access_size_e'(size_i) != ACC_BAD);
    assign data_wr = wr_i && size_ok && (addr_lo == `CRC_OFS_DATA);

    // Right aligned data moved to the top, reversed first
    // input reversal
    always_comb
    begin
        packed_in = 32'h00000000;
        in_bytes = `CRC_BYTES_WORD;
        rev_in = 32'h00000000;
        unique case (access_size_e'(size_i))
            ACC_BYTE:
            begin
                in_bytes = `CRC_BYTES_BYTE;
                rev_in = rev_units(wdata_i, in_rev_e'(
                    (st.input_bit_reverse == REV_NONE)
                    ? REV_NONE : REV_BYTE));
                packed_in = {rev_in[7:0], 24'h000000};
            end
            ACC_HALF:
            begin
                in_bytes = `CRC_BYTES_HALF;
                rev_in = rev_units(wdata_i, in_rev_e'(
                    (st.input_bit_reverse == REV_WORD)
                    ? REV_HALF : st.input_bit_reverse));
                packed_in = {rev_in[15:0], 16'h0000};
            end
            ACC_WORD:
            begin
                in_bytes = `CRC_BYTES_WORD;
                packed_in = rev_units(wdata_i, st.input_bit_reverse);
            end
            ACC_BAD:
            begin
                in_bytes = `CRC_BYTES_WORD;
                packed_in = 32'h00000000;
            end
        endcase
    end

    assign read_value = st.output_bit_reverse
        ? rev_low(st.remainder, st.poly_width_sel) : st.remainder;

    // ============================================================
    // Next state
    always_comb
    begin
        next_st = st;
        next_st.soft_reset = 1'b0;
        next_st.rdata = 32'h00000000;

        // Register reads, data one cycle later
        if (rd_i)
        begin
            unique case (addr_lo)
                `CRC_OFS_DATA:
                begin
                    if (size_ok)
                    begin
                        next_st.rdata = read_value;
                    end
                end
                `CRC_OFS_SCRATCH:
                begin
                    if (is_word)
                    begin
                        next_st.rdata = {24'h000000, st.scratch_value};
                    end
                end
                `CRC_OFS_CTRL:
                begin
                    if (is_word)
                    begin
                        next_st.rdata = {24'h000000,
                            st.output_bit_reverse,
                            st.input_bit_reverse,
                            st.poly_width_sel,
                            2'b00,
                            st.soft_reset};
                    end
                end
                `CRC_OFS_INIT:
                begin
                    if (is_word)
                    begin
                        next_st.rdata = st.initial_value;
                    end
                end
                `CRC_OFS_POLY:
                begin
                    if (is_word)
                    begin
                        next_st.rdata = st.poly_coefficients;
                    end
                end
                default:
                begin
                    next_st.rdata = 32'h00000000;
                end
            endcase
        end

        // One byte per clock while folding
        // byte per cycle
        unique case (st.engine)
            ENG_IDLE:
            begin
                next_st.engine = ENG_IDLE;
            end
            ENG_FOLD:
            begin
                next_st.remainder = folded;
                next_st.shift_data = {st.shift_data[23:0], 8'h00};
                next_st.bytes_left = st.bytes_left - 3'h1;
                if (st.bytes_left == 3'h1)
                begin
                    if (st.pend_valid)
                    begin
                        next_st.shift_data = st.pend_data;
                        next_st.bytes_left = st.pend_bytes;
                        next_st.pend_valid = 1'b0;
                    end
                    else
                    begin
                        next_st.engine = ENG_IDLE;
                    end
                end
            end
        endcase

        // New data write starts folding, waits in the buffer, or is dropped if the buffer is full
        if (data_wr)
        begin
            if (next_st.engine == ENG_IDLE)
            begin
                next_st.engine = ENG_FOLD;
                next_st.shift_data = packed_in;
                next_st.bytes_left = in_bytes;
            end
            else if (!next_st.pend_valid)
            begin
                next_st.pend_valid = 1'b1;
                next_st.pend_data = packed_in;
                next_st.pend_bytes = in_bytes;
            end
        end

        // Word only registers
        if (wr_i && is_word)
        begin
            unique case (addr_lo)
                `CRC_OFS_SCRATCH:
                begin
                    next_st.scratch_value = wdata_i[7:0];
                end
                `CRC_OFS_CTRL:
                begin
                    next_st.poly_width_sel = poly_width_e'(
                        wdata_i[`CRC_CTRL_WSEL_MSB:`CRC_CTRL_WSEL_LSB]);
                    next_st.input_bit_reverse = in_rev_e'(
                        wdata_i[`CRC_CTRL_IREV_MSB:`CRC_CTRL_IREV_LSB]);
                    next_st.output_bit_reverse = wdata_i[`CRC_CTRL_OREV];
                    if (wdata_i[`CRC_CTRL_SOFT_RST])
                    begin
                        next_st.soft_reset = 1'b1;
                        next_st.remainder = st.initial_value;
                        next_st.engine = ENG_IDLE;
                        next_st.bytes_left = 3'h0;
                        next_st.pend_valid = 1'b0;
                    end
                end
                `CRC_OFS_INIT:
                begin
                    next_st.initial_value = wdata_i;
                end
                `CRC_OFS_POLY:
                begin
                    next_st.poly_coefficients = wdata_i;
                end
                default:
                begin
                    next_st.scratch_value = st.scratch_value;
                end
            endcase
        end
    end

    // ============================================================
    // State register
    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            st <= RESET_STATE;
        end
        else
        begin
            st <= next_st;
        end
    end

    // ============================================================
    // Outputs
    assign rdata_o = st.rdata;
    assign busy_o = (st.engine == ENG_FOLD) || st.pend_valid;

endmodule

// ### sim/crc_compute_unit_assertions.sv
// Port-level timing checks of the checksum unit
// Assumes the register port contract and one clock domain
`timescale 1ns/1ps
module crc_compute_unit_checker
    import crc_pkg::*;
#(
    parameter int ADDR_W = 8
)
(
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic [ADDR_W-1:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic [1:0] size_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [31:0] rdata_o,
    input wire logic busy_o
);
    localparam logic [ADDR_W-1:0] A_DAT = ADDR_W'(8'h00);
    localparam logic [ADDR_W-1:0] A_SCR = ADDR_W'(8'h04);
    localparam logic [ADDR_W-1:0] A_CTL = ADDR_W'(8'h08);
    localparam logic [ADDR_W-1:0] A_INI = ADDR_W'(8'h10);
    localparam logic [ADDR_W-1:0] A_POL = ADDR_W'(8'h14);
    logic dat_wr;
    logic reg_ok;
    assign dat_wr = wr_i && addr_i == A_DAT && size_i != 2'b11;
    assign reg_ok = addr_i inside {A_SCR, A_CTL, A_INI, A_POL};

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!arst_n_i);

    // ============================================================
    // Fold timing
    property p_word_busy;
        dat_wr && size_i == 2'b10 && !busy_o |=> busy_o[*4];
    endproperty
    a_word_busy: assert property (p_word_busy)
        else $error("word fold not four cycles");
    property p_half_busy;
        (dat_wr && size_i == 2'b01 && !busy_o) ##1 (!wr_i)[*2]
            |-> $past(busy_o) && busy_o ##1 !busy_o;
    endproperty
    a_half_busy: assert property (p_half_busy)
        else $error("half fold not two cycles");
    property p_byte_busy;
        (dat_wr && size_i == 2'b00 && !busy_o) ##1 !wr_i
            |-> busy_o ##1 !busy_o;
    endproperty
    a_byte_busy: assert property (p_byte_busy)
        else $error("byte fold not one cycle");
    property p_buf;
        dat_wr && busy_o |=> busy_o;
    endproperty
    a_buf: assert property (p_buf)
        else $error("buffered write lost busy");
    property p_bad_wr;
        wr_i && !busy_o && !dat_wr |=> !busy_o;
    endproperty
    a_bad_wr: assert property (p_bad_wr)
        else $error("fold started by non-data write");

    // ============================================================
    // Read data
    property p_rd_idle;
        !rd_i |=> rdata_o == 32'h00000000;
    endproperty
    a_rd_idle: assert property (p_rd_idle)
        else $error("read data outside read cycle");
    property p_bad_rd;
        rd_i && addr_i != A_DAT && !(reg_ok && size_i == 2'b10)
            |=> rdata_o == 32'h00000000;
    endproperty
    a_bad_rd: assert property (p_bad_rd)
        else $error("refused read not zero");
    property p_ctl_rsv;
        rd_i && addr_i == A_CTL |=>
            rdata_o[31:8] == 24'h000000 && rdata_o[2:1] == 2'b00;
    endproperty
    a_ctl_rsv: assert property (p_ctl_rsv)
        else $error("control reserved bits not zero");
    property p_scr_rsv;
        rd_i && addr_i == A_SCR |=> rdata_o[31:8] == 24'h000000;
    endproperty
    a_scr_rsv: assert property (p_scr_rsv)
        else $error("scratch upper bits not zero");
    property p_srst_clr;
        rd_i && addr_i == A_CTL && !$past(wr_i) |=> !rdata_o[0];
    endproperty
    a_srst_clr: assert property (p_srst_clr)
        else $error("soft reset bit not cleared");
endmodule
bind crc_compute_unit crc_compute_unit_checker #(.ADDR_W(ADDR_W)) u_chk (
    .clk_i(clk_i),
    .arst_n_i(arst_n_i),
    .addr_i(addr_i),
    .wdata_i(wdata_i),
    .size_i(size_i),
    .wr_i(wr_i),
    .rd_i(rd_i),
    .rdata_o(rdata_o),
    .busy_o(busy_o)
);

// ### sim/testbench.sv
// Self-checking bench of the checksum unit with a reference model
// Assumes the checker is bound to the unit by its own file
`timescale 1ns/1ps
module testbench
    import crc_pkg::*;
;
    logic clk_i = 1'b0;
    logic arst_n_i = 1'b0;
    logic [7:0] addr_i = 8'h00;
    logic [31:0] wdata_i = 32'h00000000;
    logic [1:0] size_i = 2'b00;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic [31:0] rdata_o;
    logic busy_o;
    int n_fail = 0;
    int n_checks = 0;
    logic [1:0] w;
    logic [1:0] ir;
    logic orv;
    logic [31:0] pol;
    logic [31:0] ini;
    logic [31:0] mdl;
    logic [31:0] polt [4] = '{32'h04C11DB7, 32'h00008005,
        32'h00000007, 32'h00000009};

    crc_compute_unit #(.ADDR_W(8)) u_crc_compute_unit (
        .clk_i(clk_i),
        .arst_n_i(arst_n_i),
        .addr_i(addr_i),
        .wdata_i(wdata_i),
        .size_i(size_i),
        .wr_i(wr_i),
        .rd_i(rd_i),
        .rdata_o(rdata_o),
        .busy_o(busy_o)
    );

    initial
    begin
        forever #12.5 clk_i = ~clk_i;
    end

    // ============================================================
    // Reference model
    function automatic int wid();
        return (w == 2'b00) ? 32 : (w == 2'b01) ? 16 : (w == 2'b10) ? 8 : 7;
    endfunction
    function automatic logic [31:0] rv(input logic [31:0] d, input int n);
        rv = d;
        for (int i = 0; i < n; i++) rv[i] = d[n-1-i];
    endfunction
    function automatic logic [31:0] irv(input logic [31:0] d, input int nb);
        int u;
        u = (ir == 2'b01) ? 8 : (ir == 2'b10) ? 16 : (ir == 2'b11) ? 32 : 0;
        if (u > nb * 8) u = nb * 8;
        irv = d;
        if (u > 0)
            for (int i = 0; i < nb * 8; i++) irv[i] = d[(i/u)*u+u-1-(i%u)];
    endfunction
    function automatic logic [31:0] fold(input logic [31:0] d, input int nb);
        int wb;
        logic [31:0] m;
        logic [31:0] r;
        logic fb;
        wb = wid();
        m = (wb == 32) ? 32'hFFFFFFFF : ((32'h1 << wb) - 32'h1);
        r = mdl & m;
        for (int i = nb * 8 - 1; i >= 0; i--)
        begin
            fb = r[wb-1] ^ d[i];
            r = (r << 1) & m;
            if (fb) r = r ^ (pol & m);
        end
        return r;
    endfunction
    function automatic logic [31:0] ex();
        return orv ? rv(mdl, wid()) : mdl;
    endfunction

    // ============================================================
    // Bus tasks and checks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            n_fail++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
        input logic [1:0] s);
        @(posedge clk_i);
        wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= d;
        size_i <= s;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk_i);
        rd_i <= 1'b1;
        addr_i <= a;
        size_i <= 2'b10;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1 chk(rdata_o, exp);
    endtask
    task automatic wdat(input logic [31:0] d, input int nb);
        wr(8'h00, d, (nb == 4) ? 2'b10 : (nb == 2) ? 2'b01 : 2'b00);
        mdl = fold(irv(d, nb), nb);
    endtask
    task automatic idle();
        int k;
        k = 0;
        #1;
        while (busy_o !== 1'b0 && k < 20)
        begin
            @(posedge clk_i);
            #1 k++;
        end
        chk({31'h0, busy_o}, 32'h0);
    endtask
    task automatic wrap_up();
        $display("checks %0d failures %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    initial
    begin
        repeat (20000) @(posedge clk_i);
        n_fail++;
        wrap_up();
    end

    // ============================================================
    // Scenarios
    initial
    begin
        w = 2'b00;
        ir = 2'b00;
        orv = 1'b0;
        pol = 32'h04C11DB7;
        ini = 32'hFFFFFFFF;
        mdl = 32'hFFFFFFFF;
        repeat (10) @(posedge clk_i);
        arst_n_i <= 1'b1;
        rd(8'h00, 32'hFFFFFFFF);
        rd(8'h04, 32'h00000000);
        rd(8'h08, 32'h00000000);
        rd(8'h10, 32'hFFFFFFFF);
        rd(8'h14, 32'h04C11DB7);
        rd(8'h0C, 32'h00000000);
        wr(8'h04, 32'hFFFFFF5A, 2'b10);
        rd(8'h04, 32'h0000005A);
        wr(8'h08, 32'hFFFFFFFE, 2'b00);
        rd(8'h08, 32'h00000000);
        wdat(32'h12345678, 4);
        idle();
        rd(8'h00, ex());
        wdat(32'hFFFFA1B2, 2);
        idle();
        rd(8'h00, ex());
        wr(8'h00, 32'hA5A5A5A5, 2'b11);
        idle();
        rd(8'h00, ex());
        wr(8'h08, 32'hFFFFFFFF, 2'b10);
        w = 2'b11;
        ir = 2'b11;
        orv = 1'b1;
        mdl = ini;
        @(posedge clk_i);
        rd(8'h08, 32'h000000F8);
        rd(8'h04, 32'h0000005A);
        rd(8'h00, ex());
        for (int wi = 0; wi < 4; wi++)
        begin
            for (int ii = 0; ii < 4; ii++)
            begin
                w = wi[1:0];
                ir = ii[1:0];
                orv = wi[0] ^ ii[0];
                pol = polt[wi];
                ini = 32'h89ABCDEF ^ {26'h0, w, 2'b00, ir};
                wr(8'h14, pol, 2'b10);
                wr(8'h10, ini, 2'b10);
                wr(8'h08, {24'h0, orv, ir, w, 3'b001}, 2'b10);
                mdl = ini;
                wdat(32'hC3A51E7F, 4);
                wdat(32'hFFFFB4D2, 2);
                idle();
                wdat(32'hFFFFFF6E, 1);
                idle();
                rd(8'h00, ex());
            end
        end
        rd(8'h14, 32'h00000009);
        wrap_up();
    end
endmodule
